/* File: temp_limit_fault_response.sv */
/*
  temperature thresholds and under-temperature fault response.
  holds the three limit words and the action byte behind a decoded
  command port, compares the temperature and sequences the output.
  assumes the serial front end decodes each transfer into one
  command pulse, and temperature arrives on this clock.
*/
`timescale 1ns/1ps
module temp_limit_fault_response #(
  parameter int RETRY_UNIT_CYCLES = tlim_pkg::RETRY_UNIT_CYCLES,
  parameter int RUN_UNIT_CYCLES   = tlim_pkg::RUN_UNIT_CYCLES
) (
  input  wire logic        clk_in,          // core clock
  input  wire logic        resetn_in,       // async reset
  input  wire logic        cmd_valid_in,    // transfer pulse
  input  wire logic [7:0]  cmd_code_in,     // command code
  input  wire logic        cmd_write_in,    // 1 write, 0 read
  input  wire logic        cmd_word_in,     // 1 word, 0 byte
  input  wire logic [15:0] cmd_wdata_in,    // write data
  output logic             cmd_ack_out,     // accepted pulse
  output logic             cmd_nack_out,    // refused pulse
  output logic [15:0]      cmd_rdata_out,   // read data
  input  wire logic [15:0] temp_in,         // linear temperature
  input  wire logic        enable_cmd_in,   // output commanded on
  input  wire logic        other_fault_in,  // shutdown by others
  input  wire logic        fault_clear_in,  // clear faults pulse
  output logic             output_enable_out, // regulate
  output logic             alert_out_n,     // alert, low active
  output logic             ut_fault_out,    // status: fault
  output logic             ut_warn_out,     // status: low warn
  output logic             ot_warn_out      // status: high warn
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]    ot_warn;  // over-temp warning limit
    logic [15:0]    ut_warn;  // under-temp warning limit
    logic [15:0]    ut_fault; // under-temp fault limit
    logic [7:0]     action;   // response byte
    logic [15:0]    rdata;    // read data
    logic           ack;      // accepted pulse
    logic           nack;     // refused pulse
    tlim_pkg::fsm_t fsm;      // sequencer
    logic [2:0]     tries;    // failed attempts so far
    logic           out_en;   // output enable
  } top_state_t;

  top_state_t s;      // registered copy
  top_state_t next_s; // next value

  // ==========================================================
  // action fields and comparisons
  logic [1:0] resp;       // response code
  logic [2:0] retry;      // retry setting
  logic [2:0] delay;      // delay units
  logic       fault_now;  // below fault limit
  logic       low_warn;   // below warning limit
  logic       high_warn;  // above warning limit
  logic       tmr_start;  // load the timer
  logic       tmr_cancel; // stop the timer
  logic       tmr_done;   // timer end pulse
  logic [tlim_pkg::CYC_W-1:0] unit_cycles; // unit length
  logic [2:0] flags;      // sticky status
  logic       cmd_ok;     // code and size agree

  assign resp  = s.action[tlim_pkg::ACT_RESP_HI:tlim_pkg::ACT_RESP_LO];
  assign retry = s.action[tlim_pkg::ACT_RETRY_HI:tlim_pkg::ACT_RETRY_LO];
  assign delay = s.action[tlim_pkg::ACT_DELAY_HI:tlim_pkg::ACT_DELAY_LO];

  // fault below its limit; warnings never touch the output
  assign fault_now = tlim_pkg::lin_below(temp_in, s.ut_fault);
  assign low_warn  = tlim_pkg::lin_below(temp_in, s.ut_warn);
  assign high_warn = tlim_pkg::lin_below(s.ot_warn, temp_in);

  // ==========================================================
  // command decode: thresholds by word, action by byte
  always_comb begin
    unique case (cmd_code_in)
      tlim_pkg::CMD_OT_WARN,
      tlim_pkg::CMD_UT_WARN,
      tlim_pkg::CMD_UT_FAULT:  cmd_ok = cmd_word_in;
      tlim_pkg::CMD_UT_ACTION: cmd_ok = !cmd_word_in;
      default:                 cmd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // run-on delay uses the long unit, attempt spacing the short one
  always_comb begin
    if (next_s.fsm == tlim_pkg::ST_RUN_DELAY) begin
      unit_cycles = tlim_pkg::CYC_W'(RUN_UNIT_CYCLES);
    end else begin
      unit_cycles = tlim_pkg::CYC_W'(RETRY_UNIT_CYCLES);
    end
  end

  // ==========================================================
  // registers, read data and the response sequencer
  always_comb begin
    next_s      = s;
    next_s.ack  = 1'b0;
    next_s.nack = 1'b0;
    tmr_start   = 1'b0;
    tmr_cancel  = 1'b0;

    // command port: answer on the edge after the pulse
    if (cmd_valid_in) begin
      next_s.ack  = cmd_ok;
      next_s.nack = !cmd_ok;
      if (cmd_ok && cmd_write_in) begin
        unique case (cmd_code_in)
          tlim_pkg::CMD_OT_WARN:  next_s.ot_warn  = cmd_wdata_in;
          tlim_pkg::CMD_UT_WARN:  next_s.ut_warn  = cmd_wdata_in;
          tlim_pkg::CMD_UT_FAULT: next_s.ut_fault = cmd_wdata_in;
          default: next_s.action = cmd_wdata_in[7:0];
        endcase
      end else if (cmd_ok) begin
        unique case (cmd_code_in)
          tlim_pkg::CMD_OT_WARN:  next_s.rdata = s.ot_warn;
          tlim_pkg::CMD_UT_WARN:  next_s.rdata = s.ut_warn;
          tlim_pkg::CMD_UT_FAULT: next_s.rdata = s.ut_fault;
          default: next_s.rdata = {8'h00, s.action};
        endcase
      end
    end

    // sequencer
    unique case (s.fsm)
      tlim_pkg::ST_RUN: begin
        // a disabled output has nothing to respond with
        if (fault_now && enable_cmd_in) begin
          unique case (resp)
            tlim_pkg::RESP_IGNORE: begin
              next_s.fsm = tlim_pkg::ST_IGNORE;
            end
            tlim_pkg::RESP_RUN_DLY: begin
              next_s.fsm = tlim_pkg::ST_RUN_DELAY;
              tmr_start  = 1'b1;
            end
            tlim_pkg::RESP_RETRY: begin
              next_s.tries = 3'h0;
              if (retry == tlim_pkg::RETRY_NONE) begin
                next_s.fsm = tlim_pkg::ST_LATCHED;
              end else begin
                next_s.fsm = tlim_pkg::ST_RETRY;
                tmr_start  = 1'b1;
              end
            end
            default: begin
              next_s.fsm = tlim_pkg::ST_HOLD;
            end
          endcase
        end
      end
      tlim_pkg::ST_IGNORE: begin
        if (!fault_now) begin
          next_s.fsm = tlim_pkg::ST_RUN;
        end
      end
      tlim_pkg::ST_RUN_DELAY: begin
        // still regulating; decide when the delay ends
        if (tmr_done) begin
          next_s.tries = 3'h0;
          if (!fault_now) begin
            next_s.fsm = tlim_pkg::ST_RUN;
          end else if (retry == tlim_pkg::RETRY_NONE) begin
            next_s.fsm = tlim_pkg::ST_LATCHED;
          end else begin
            next_s.fsm = tlim_pkg::ST_RETRY;
            tmr_start  = 1'b1;
          end
        end
      end
      tlim_pkg::ST_RETRY: begin
        // an attempt succeeds if the fault has gone at its start
        if (tmr_done) begin
          if (!fault_now) begin
            next_s.fsm = tlim_pkg::ST_RUN;
          end else if (retry == tlim_pkg::RETRY_FOREVER) begin
            tmr_start = 1'b1;
          end else if (s.tries + 3'h1 >= retry) begin
            next_s.fsm = tlim_pkg::ST_LATCHED;
          end else begin
            next_s.tries = s.tries + 3'h1;
            tmr_start    = 1'b1;
          end
        end
        // commanding the output off ends the retries
        if (!enable_cmd_in) begin
          next_s.fsm = tlim_pkg::ST_RUN;
          tmr_cancel = 1'b1;
        end
      end
      tlim_pkg::ST_HOLD: begin
        if (!fault_now) begin
          next_s.fsm = tlim_pkg::ST_RUN;
        end
      end
      tlim_pkg::ST_LATCHED: begin
        if (fault_clear_in) begin
          next_s.fsm = tlim_pkg::ST_RUN;
        end
      end
    endcase

    // another fault's shutdown overrides everything
    if (other_fault_in) begin
      next_s.fsm = tlim_pkg::ST_LATCHED;
      tmr_cancel = 1'b1;
      tmr_start  = 1'b0;
    end

    // output is on only in the regulating states
    next_s.out_en = enable_cmd_in &&
                    (next_s.fsm == tlim_pkg::ST_RUN ||
                     next_s.fsm == tlim_pkg::ST_IGNORE ||
                     next_s.fsm == tlim_pkg::ST_RUN_DELAY);
  end

  // register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s          <= '0;
      s.ot_warn  <= tlim_pkg::RST_OT_WARN;
      s.ut_warn  <= tlim_pkg::RST_UT_WARN;
      s.ut_fault <= tlim_pkg::RST_UT_FAULT;
      s.action   <= tlim_pkg::RST_UT_ACTION;
      s.fsm      <= tlim_pkg::ST_RUN;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // delay and spacing timer
  unit_timer u_timer (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .start_in       (tmr_start),
    .cancel_in      (tmr_cancel),
    .units_in       (delay),
    .unit_cycles_in (unit_cycles),
    .done_out       (tmr_done)
  );

  // ==========================================================
  // status flags: bit 0 fault, 1 low warn, 2 high warn
  sticky_flags u_flags (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    ({high_warn, low_warn, fault_now}),
    .clear_in  (fault_clear_in),
    .flags_out (flags)
  );

  // ==========================================================
  // outputs
  assign cmd_ack_out       = s.ack;
  assign cmd_nack_out      = s.nack;
  assign cmd_rdata_out     = s.rdata;
  assign output_enable_out = s.out_en;
  assign ut_fault_out      = flags[0];
  assign ut_warn_out       = flags[1];
  assign ot_warn_out       = flags[2];
  assign alert_out_n       = !flags[0];

  // ==========================================================
  // checks
  AST_ALERT_ON_FAULT: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    fault_now |=> (!alert_out_n && ut_fault_out)
  ) else $error("alert not low after fault");

  AST_IGNORE_RUNS: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_RUN && fault_now && enable_cmd_in &&
     resp == tlim_pkg::RESP_IGNORE && !other_fault_in)
    |=> output_enable_out
  ) else $error("ignored fault stopped output");

  AST_RUN_DELAY_ON: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_RUN_DELAY && enable_cmd_in &&
     !tmr_done && !other_fault_in) |=> output_enable_out
  ) else $error("output dropped during run-on delay");

  AST_DISABLE_NOW: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_RUN && fault_now && enable_cmd_in &&
     resp == tlim_pkg::RESP_RETRY) |=> !output_enable_out
  ) else $error("output not disabled at once");

  AST_HOLD_RESUME: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_HOLD && !fault_now && enable_cmd_in &&
     !other_fault_in) |=> output_enable_out
  ) else $error("output did not resume after fault");

  AST_LATCH_STAYS: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_LATCHED && !fault_clear_in)
    |=> (s.fsm == tlim_pkg::ST_LATCHED && !output_enable_out)
  ) else $error("latched off left without clear");

  AST_TRY_LIMIT: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_RETRY &&
     retry != tlim_pkg::RETRY_FOREVER) |-> (s.tries < retry)
  ) else $error("more attempts than the retry setting");

  AST_FOREVER: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s.fsm == tlim_pkg::ST_RETRY && tmr_done && fault_now &&
     retry == tlim_pkg::RETRY_FOREVER && enable_cmd_in &&
     !other_fault_in) |=> (s.fsm == tlim_pkg::ST_RETRY)
  ) else $error("continuous retry stopped");

  AST_WORD_WRITE: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (cmd_valid_in && cmd_write_in && cmd_word_in &&
     cmd_code_in == tlim_pkg::CMD_UT_FAULT)
    |=> (s.ut_fault == $past(cmd_wdata_in) && cmd_ack_out)
  ) else $error("fault limit write lost");

  AST_SIZE_REFUSED: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (cmd_valid_in && cmd_word_in &&
     cmd_code_in == tlim_pkg::CMD_UT_ACTION) |=> cmd_nack_out
  ) else $error("word transfer to byte command taken");

endmodule : temp_limit_fault_response

/* File: tlim_pkg.sv */
/*
  constants, state types and linear-format helpers for the temperature
  limit and under-temperature fault response block.
  assumes a 100 MHz core clock; nothing else is needed from outside.
*/
package tlim_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_OT_WARN   = 8'h51; // word
  localparam logic [7:0] CMD_UT_WARN   = 8'h52; // word
  localparam logic [7:0] CMD_UT_FAULT  = 8'h53; // word
  localparam logic [7:0] CMD_UT_ACTION = 8'h54; // byte

  // ==========================================================
  // action byte fields
  localparam int ACT_RESP_HI  = 7;
  localparam int ACT_RESP_LO  = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;

  localparam logic [1:0] RESP_IGNORE  = 2'h0; // keep running
  localparam logic [1:0] RESP_RUN_DLY = 2'h1; // run, then retry
  localparam logic [1:0] RESP_RETRY   = 2'h2; // off, then retry
  localparam logic [1:0] RESP_HOLD    = 2'h3; // off while present
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ==========================================================
  // values after reset
  localparam logic [15:0] RST_OT_WARN   = 16'h007d; // +125 C
  localparam logic [15:0] RST_UT_WARN   = 16'h07d8; // -40 C
  localparam logic [15:0] RST_UT_FAULT  = 16'h07d3; // -45 C
  localparam logic [7:0]  RST_UT_ACTION = 8'hc0;    // hold off

  // ==========================================================
  // timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int RETRY_UNIT_MS = 32;
  localparam int RUN_UNIT_MS   = 80;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);
  localparam int RUN_UNIT_CYCLES   = RUN_UNIT_MS * (CLK_HZ / 1000);
  localparam int CYC_W = 24; // holds 8,000,000

  // ==========================================================
  // response sequencer states
  typedef enum logic [2:0] {
    ST_RUN,       // normal, no response running
    ST_IGNORE,    // fault present, ignored
    ST_RUN_DELAY, // still regulating, delay running
    ST_RETRY,     // output off, waiting for next attempt
    ST_HOLD,      // off until the fault goes away
    ST_LATCHED    // off until faults are cleared
  } fsm_t;

  // ==========================================================
  // linear word to signed fixed point, 16 fraction bits
  function automatic logic signed [47:0] linear_to_fixed(
    input logic [15:0] v
  );
    logic signed [47:0] m;
    m = 48'(signed'(v[10:0])) <<< 16;
    if (v[15]) begin
      linear_to_fixed = m >>> ({1'b0, ~v[14:11]} + 5'h01);
    end else begin
      linear_to_fixed = m <<< v[14:11];
    end
  endfunction : linear_to_fixed

  // a below b, both in linear format
  function automatic logic lin_below(
    input logic [15:0] a,
    input logic [15:0] b
  );
    lin_below = linear_to_fixed(a) < linear_to_fixed(b);
  endfunction : lin_below

endpackage : tlim_pkg

/* File: unit_timer.sv */
/*
  counts a number of delay units, each a given number of clocks.
  assumes start and cancel come from logic on the same clock.
*/
`timescale 1ns/1ps
module unit_timer (
  input  wire logic                   clk_in,         // core clock
  input  wire logic                   resetn_in,      // async reset
  input  wire logic                   start_in,       // load and run
  input  wire logic                   cancel_in,      // abort count
  input  wire logic [2:0]             units_in,       // unit count
  input  wire logic [tlim_pkg::CYC_W-1:0] unit_cycles_in, // per unit
  output logic                        done_out        // end pulse
);

  // ==========================================================
  // state
  typedef struct packed {
    logic                       busy;  // counting
    logic [2:0]                 left;  // units still to run
    logic [tlim_pkg::CYC_W-1:0] cyc;   // clocks left in unit
    logic                       done;  // end pulse
  } tmr_state_t;

  tmr_state_t s;      // registered copy
  tmr_state_t next_s; // next value

  // ==========================================================
  // next state; zero units ends on the next edge
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (cancel_in) begin
      next_s.busy = 1'b0;
    end else if (start_in) begin
      next_s.busy = (units_in != 3'h0);
      next_s.done = (units_in == 3'h0);
      next_s.left = units_in;
      next_s.cyc  = unit_cycles_in - 1'b1;
    end else if (s.busy) begin
      if (s.cyc != '0) begin
        next_s.cyc = s.cyc - 1'b1;
      end else if (s.left == 3'h1) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.left = s.left - 3'h1;
        next_s.cyc  = unit_cycles_in - 1'b1;
      end
    end
  end

  // register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done_out = s.done;

endmodule : unit_timer

/* File: sticky_flags.sv */
/*
  three sticky status flags: set by events, cleared by one pulse.
  assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module sticky_flags (
  input  wire logic       clk_in,    // core clock
  input  wire logic       resetn_in, // async reset
  input  wire logic [2:0] set_in,    // event levels
  input  wire logic       clear_in,  // clear all
  output logic [2:0]      flags_out  // held flags
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0] flags; // held events
  } flg_state_t;

  flg_state_t s;      // registered copy
  flg_state_t next_s; // next value

  // set beats clear so no event is lost in the clear cycle
  always_comb begin
    next_s = s;
    if (clear_in) begin
      next_s.flags = 3'h0;
    end
    next_s.flags = next_s.flags | set_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flags_out = s.flags;

endmodule : sticky_flags

/* File: host_model.sv */
/*
  host side model: issues decoded read and write command transfers.
  assumes the block answers at the edge that takes them.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_in,    // core clock
  input  wire logic        ack_in,    // accepted pulse
  input  wire logic        nack_in,   // refused pulse
  input  wire logic [15:0] rdata_in,  // read data
  output logic             valid_out, // transfer pulse
  output logic [7:0]       code_out,  // command code
  output logic             write_out, // 1 write, 0 read
  output logic             word_out,  // 1 word, 0 byte
  output logic [15:0]      wdata_out  // write data
);
  // ======================================
  // idle values at time zero
  initial begin
    valid_out = 1'b0;
    code_out  = 8'h00;
    write_out = 1'b0;
    word_out  = 1'b0;
    wdata_out = 16'h0000;
  end

  // ======================================
  // one transfer: pulse, then read the answer
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                      input logic [15:0] d, output logic a,
                      output logic n, output logic [15:0] r);
    @(posedge clk_in);
    valid_out <= 1'b1;
    code_out  <= c;
    write_out <= w;
    word_out  <= wd;
    wdata_out <= d;
    @(posedge clk_in);
    // released code and data lines show inverted values, never a stale copy
    valid_out <= 1'b0;
    code_out  <= ~c;
    wdata_out <= ~d;
    #1;
    a = ack_in;
    n = nack_in;
    r = rdata_in;
  endtask : xfer
endmodule : host_model

/* File: temp_limit_fault_response_tb.sv */
/*
  bench: register access, thresholds and each fault response.
  assumes tlim_pkg and host_model; unit lengths shortened to 4 and 10 clocks.
*/
`timescale 1ns/1ps
module temp_limit_fault_response_tb;
  // ======================================
  // signals
  logic        clk_in, resetn_in, cmd_valid_in, cmd_write_in, cmd_word_in;
  logic        cmd_ack_out, cmd_nack_out, enable_cmd_in, other_fault_in;
  logic        fault_clear_in, output_enable_out, alert_out_n;
  logic        ut_fault_out, ut_warn_out, ot_warn_out;
  logic [7:0]  cmd_code_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, temp_in;
  int          fail_count, checked;
  // temperatures: +25 C, -50 C, +130 C, -42 C
  localparam logic [15:0] T_NORM = 16'h0019, T_COLD = 16'h07ce;
  localparam logic [15:0] T_HOT = 16'h0082, T_COOL = 16'h07d6;
  localparam logic [15:0] RST_W [3] = '{tlim_pkg::RST_OT_WARN,
    tlim_pkg::RST_UT_WARN, tlim_pkg::RST_UT_FAULT};
  localparam logic [7:0] RETRY_ACT [3] = '{8'h89, 8'hb1, 8'hb9};

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  temp_limit_fault_response #(.RETRY_UNIT_CYCLES(4), .RUN_UNIT_CYCLES(10))
    u_temp_limit_fault_response (.clk_in, .resetn_in, .cmd_valid_in,
    .cmd_code_in, .cmd_write_in, .cmd_word_in, .cmd_wdata_in, .cmd_ack_out,
    .cmd_nack_out, .cmd_rdata_out, .temp_in, .enable_cmd_in,
    .other_fault_in, .fault_clear_in, .output_enable_out, .alert_out_n,
    .ut_fault_out, .ut_warn_out, .ot_warn_out);

  host_model u_host_model (.clk_in(clk_in), .ack_in(cmd_ack_out),
    .nack_in(cmd_nack_out), .rdata_in(cmd_rdata_out),
    .valid_out(cmd_valid_in), .code_out(cmd_code_in),
    .write_out(cmd_write_in), .word_out(cmd_word_in),
    .wdata_out(cmd_wdata_in));

  // ======================================
  // reporting
  task end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ======================================
  // access, temperature and output helpers
  task acc(input logic w, input logic wd, input logic [7:0] c,
           input logic [15:0] d, input logic ea, input logic [15:0] er);
    logic a, n;
    logic [15:0] r;
    u_host_model.xfer(w, wd, c, d, a, n, r);
    chk("ack", {15'h0, ea}, {15'h0, a});
    chk("nack", {15'h0, ~ea}, {15'h0, n});
    if (!w && ea) begin
      chk("rdata", er, r);
    end
  endtask : acc

  task tset(input logic [15:0] t);
    @(posedge clk_in);
    temp_in <= t;
    // step off the edge so no caller reads outputs as they launch
    #1;
  endtask : tset

  // output must hold e for n cycles
  task stay(input logic e, input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
      chk("output_enable held", {15'h0, e}, {15'h0, output_enable_out});
    end
  endtask : stay

  // output must reach e within hi cycles; a hang ends the run
  task wait_out(input logic e, input int hi);
    int k;
    for (k = 0; k < hi && output_enable_out !== e; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk("output_enable", {15'h0, e}, {15'h0, output_enable_out});
    if (output_enable_out !== e) begin
      end_sim;
    end
  endtask : wait_out

  // warm again, then pulse the fault clear
  task clr;
    tset(T_NORM);
    @(posedge clk_in);
    fault_clear_in <= 1'b1;
    @(posedge clk_in);
    fault_clear_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : clr

  // ======================================
  // watchdog, far longer than the whole sequence
  initial begin
    #500us;
    fail_count++;
    end_sim;
  end

  // ======================================
  // main sequence
  initial begin
    int i;
    resetn_in = 1'b0;
    temp_in = T_NORM;
    enable_cmd_in = 1'b1;
    other_fault_in = 1'b0;
    fault_clear_in = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    // limit words: reset value, write, read back, restore
    for (i = 0; i < 3; i++) begin
      acc(0, 1, 8'h51 + 8'(i), 0, 1, RST_W[i]);
      acc(1, 1, 8'h51 + 8'(i), 16'ha55a ^ 16'(i), 1, 0);
      acc(0, 1, 8'h51 + 8'(i), 0, 1, 16'ha55a ^ 16'(i));
      acc(1, 1, 8'h51 + 8'(i), RST_W[i], 1, 0);
    end
    acc(0, 0, 8'h54, 0, 1, {8'h00, tlim_pkg::RST_UT_ACTION});
    acc(0, 0, 8'h51, 0, 0, 0);
    acc(1, 1, 8'h54, 16'h0000, 0, 0);
    acc(0, 0, 8'h54, 0, 1, {8'h00, tlim_pkg::RST_UT_ACTION});
    $display("test registers done");
    // warnings flag only
    tset(T_HOT);
    stay(1, 3);
    chk("ot_warn", 16'h1, {15'h0, ot_warn_out});
    tset(T_COOL);
    stay(1, 3);
    chk("ut_warn", 16'h1, {15'h0, ut_warn_out});
    chk("ut_fault", 16'h0, {15'h0, ut_fault_out});
    clr();
    $display("test warnings done");
    // ignore: keeps running, still alerts
    acc(1, 0, 8'h54, 16'ha500, 1, 0);
    tset(T_COLD);
    stay(1, 20);
    chk("alert_out_n", 16'h0, {15'h0, alert_out_n});
    chk("ut_fault", 16'h1, {15'h0, ut_fault_out});
    clr();
    chk("alert_out_n", 16'h1, {15'h0, alert_out_n});
    $display("test ignore done");
    // run on for one 80 ms unit, no retry: latched
    acc(1, 0, 8'h54, 16'h0041, 1, 0);
    tset(T_COLD);
    stay(1, 11);
    wait_out(0, 2);
    tset(T_NORM);
    stay(0, 20);
    clr();
    wait_out(1, 4);
    // disable at once, no retry
    acc(1, 0, 8'h54, 16'h0080, 1, 0);
    tset(T_COLD);
    wait_out(0, 3);
    chk("alert_out_n", 16'h0, {15'h0, alert_out_n});
    clr();
    wait_out(1, 4);
    // two 32 ms units between attempts
    acc(1, 0, 8'h54, 16'h008a, 1, 0);
    tset(T_COLD);
    wait_out(0, 3);
    tset(T_NORM);
    stay(0, 7);
    wait_out(1, 2);
    clr();
    // one, six, endless attempts against a lasting fault
    for (i = 0; i < 3; i++) begin
      acc(1, 0, 8'h54, {8'h00, RETRY_ACT[i]}, 1, 0);
      tset(T_COLD);
      wait_out(0, 3);
      stay(0, 60);
      tset(T_NORM);
      if (i < 2) begin
        stay(0, 20);
      end else begin
        wait_out(1, 12);
      end
      clr();
      wait_out(1, 4);
    end
    $display("test retries done");
    // hold off while cold, resume by itself
    acc(1, 0, 8'h54, 16'h00c0, 1, 0);
    tset(T_COLD);
    wait_out(0, 3);
    stay(0, 10);
    tset(T_NORM);
    wait_out(1, 4);
    $display("test hold done");
    // another fault's shutdown latches the output off until cleared
    @(posedge clk_in);
    other_fault_in <= 1'b1;
    stay(0, 3);
    @(posedge clk_in);
    other_fault_in <= 1'b0;
    stay(0, 5);
    clr();
    wait_out(1, 4);
    $display("test other fault done");
    end_sim;
  end
endmodule : temp_limit_fault_response_tb
